/* File: src/qup_defs.vh */
`ifndef QUP_DEFS_VH
`define QUP_DEFS_VH
// register word offsets (byte address = 4 * index)
`define QUP_REG_CTRL 4'h0
`define QUP_REG_FTW 4'h1
`define QUP_REG_CFG2 4'h2
`define QUP_REG_PROF_SEL 4'h3
`define QUP_REG_AUX 4'h4
`define QUP_REG_STATUS 4'h5
`define QUP_REG_PROF_BASE 4'h8
// ctrl and cfg2 fields
`define QUP_CTRL_MODE_BIT 0
`define QUP_CTRL_SINE_BIT 1
`define QUP_CTRL_ISINC_BIT 2
`define QUP_CFG2_ASF_BYP_BIT 24
// profile word fields
`define QUP_PROF_ASF_LSB 0
`define QUP_PROF_POW_LSB 14
`define QUP_PROF_OSF_LSB 28
`define QUP_PROF_INV_BIT 36
// reset values
`define QUP_AUX_RST 8'h7F
`define QUP_OSF_UNITY 8'h80
`define QUP_ASF_RST 14'h3FFF
// taps
`define QUP_TAP0 (-16'sd35)
`define QUP_TAP1 (16'sd134)
`define QUP_TAP2 (-16'sd562)
`define QUP_TAP3 (16'sd6729)
`endif

/* File: src/qup_output.v */
// Function
// [R1] Upconvert mode at 500 MSPS or more needs interpolation factor two or more.
// [R2] Serial I/Q mode minimum factor: 3, 2 or 1 by clock rate band.
// [R3] Per-profile inversion bit selects I*cos minus or plus Q*sin.
// [R4] I times cosine and Q times sine, summed into one stream.
// [R5] Baseband arrives every clock; one modulated sample per clock.
// [R6] Single tone outputs sine or cosine by select bit.
// [R7] Output frequency is tuning word over 2^32 times clock.
// [R8] Tuning word writable at run time, takes effect next clock.
// [R9] Single tone amplitude scaled by 14-bit fraction.
// [R10] Bit 24 of second config register bypasses amplitude multiplier.
// [R11] 14-bit phase offset added at accumulator MSB before lookup.
// [R12] Eight profiles each hold amplitude and phase offset values.
// [R13] Symmetric 7-tap inverse sinc FIR, enabled by register bit.
// [R14] Inverse sinc FIR sits after modulator, right before DAC.
// [R15] Output gain 8-bit per profile, LSB weight 2^-7.
// [R16] Gain of unity bypasses the multiplier.
// [R17] Software should keep gain at or below unity in DAC mode.
// [R18] Auxiliary DAC 8-bit code register, resets to 127.
// [R19] Interpolation factor 6-bit; value 1 bypasses COMB_INTEGRATOR_INTERPOLATOR and its inverse.
// [R20] 32-bit accumulator adds tuning word every clock, wraps.
// [R21] Output gain saturates to full-scale 14-bit code.
//
// Added by the designer: the address map and register access over Avalon-MM.
`include "qup_defs.vh"
`default_nettype none
module qup_output #(
    parameter NPROF = 8,
    parameter DW = 14
) (
    input wire ref_clk_i, // system clock
    input wire srst_i, // sync reset, active high
    input wire [3:0] avs_address_i, // word address
    input wire avs_read_i, // read strobe
    input wire avs_write_i, // write strobe
    input wire [31:0] avs_writedata_i, // write data
    input wire [3:0] avs_byteenable_i, // byte lanes
    output reg [31:0] avs_readdata_o, // read data
    output reg avs_waitrequest_o, // stall
    input wire [17:0] bb_i_i, // baseband i, one per clock
    input wire [17:0] bb_q_i, // baseband q
    output reg [DW-1:0] dac_data_o, // signed dac sample
    output reg [7:0] aux_dac_code_o, // full-scale code
    output reg cci_bypass_o // interpolator bypass
);
    // =====================================================
    // register file
    reg [31:0] ctrl_q;
    reg [31:0] ftw_q;
    reg [31:0] cfg2_q;
    reg [2:0] prof_sel_q;
    reg [7:0] aux_q;
    reg [5:0] cci_q;
    reg [27:0] prof_q [0:NPROF-1];
    reg [31:0] phase_q;
    reg ack_q;
    integer k;
    integer j;

    function [31:0] be_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] be;
        integer b;
        begin
            be_merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (be[b])
                    be_merge[b*8 +: 8] = nw[b*8 +: 8];
        end
    endfunction

    wire req = (avs_read_i | avs_write_i) & ~ack_q;
    wire wr = avs_write_i & ~ack_q;
    wire prof_hit = avs_address_i[3];
    wire [2:0] pidx = avs_address_i[2:0];
    // one wait cycle per access; answer on second edge
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            ack_q <= 1'b0;
            avs_waitrequest_o <= 1'b1;
        end
        else
        begin
            ack_q <= req;
            avs_waitrequest_o <= ~req;
        end
    end

    // writes land on the accepting edge
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            ctrl_q <= 32'h0000_0000;
            ftw_q <= 32'h0000_0000;
            cfg2_q <= 32'h0000_0000;
            prof_sel_q <= 3'h0;
            aux_q <= `QUP_AUX_RST; // see [R18]
            cci_q <= 6'h01;
            for (k = 0; k < NPROF; k = k + 1)
                prof_q[k] <= {14'h0000, `QUP_ASF_RST};
        end
        else if (wr)
        begin
            if (prof_hit)
            begin
                if (avs_byteenable_i[0] | avs_byteenable_i[1])
                    prof_q[pidx][27:0] <= avs_writedata_i[27:0]; // see [R12]
            end
            else if (avs_address_i == `QUP_REG_CTRL)
                ctrl_q <= be_merge(ctrl_q, avs_writedata_i, avs_byteenable_i);
            else if (avs_address_i == `QUP_REG_FTW)
                ftw_q <= be_merge(ftw_q, avs_writedata_i, avs_byteenable_i) & 32'h7FFF_FFFF; // see [R8] [R7]
            else if (avs_address_i == `QUP_REG_CFG2)
                cfg2_q <= be_merge(cfg2_q, avs_writedata_i, avs_byteenable_i);
            else if (avs_address_i == `QUP_REG_PROF_SEL)
                prof_sel_q <= avs_writedata_i[2:0];
            else if (avs_address_i == `QUP_REG_AUX)
            begin
                aux_q <= avs_writedata_i[7:0];
                cci_q <= avs_writedata_i[13:8]; // see [R19]
            end
        end
    end

    // read data captured on the taking edge, held until the next read
    // so it still stands when the master sees waitrequest low
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
            avs_readdata_o <= 32'h0000_0000;
        else if (avs_read_i & ~ack_q)
        begin
            if (prof_hit)
                avs_readdata_o <= {4'h0, prof_q[pidx][27:0]};
            else if (avs_address_i == `QUP_REG_CTRL)
                avs_readdata_o <= ctrl_q;
            else if (avs_address_i == `QUP_REG_FTW)
                avs_readdata_o <= ftw_q;
            else if (avs_address_i == `QUP_REG_CFG2)
                avs_readdata_o <= cfg2_q;
            else if (avs_address_i == `QUP_REG_PROF_SEL)
                avs_readdata_o <= {29'h0, prof_sel_q};
            else if (avs_address_i == `QUP_REG_AUX)
                avs_readdata_o <= {18'h0, cci_q, aux_q};
            else if (avs_address_i == `QUP_REG_STATUS)
                avs_readdata_o <= phase_q;
            else
                avs_readdata_o <= 32'h0000_0000;
        end
    end

    // gain and inversion bank: a profile-select write with lane 1 also stores
    // bits 15:8 as gain and bit 16 as inversion into the profile it names
    reg [8:0] gain_inv_q [0:NPROF-1];
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            for (j = 0; j < NPROF; j = j + 1)
                gain_inv_q[j] <= {1'b0, `QUP_OSF_UNITY};
        end
        else if (wr & ~prof_hit & (avs_address_i == `QUP_REG_PROF_SEL) & avs_byteenable_i[1])
            gain_inv_q[avs_writedata_i[2:0]] <= {avs_writedata_i[16], avs_writedata_i[15:8]}; // see [R15] [R3]
    end

    // =====================================================
    // carrier generator
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
            phase_q <= 32'h0000_0000;
        else
            phase_q <= phase_q + {1'b0, ftw_q[30:0]}; // see [R20] [R7]; word limited to 2^31-1
    end

    wire [13:0] amplitude_scale_value = prof_q[prof_sel_q][13:0];
    wire [13:0] phase_offset_word = prof_q[prof_sel_q][27:14];
    wire [7:0] output_gain_factor = gain_inv_q[prof_sel_q][7:0];
    wire inv = gain_inv_q[prof_sel_q][8];
    wire [13:0] ang = phase_q[31:18] + phase_offset_word; // see [R11] [R12]

    // one parabola per half turn, signed q1.15; saves a rom at a few percent shape error
    function signed [15:0] sin_ap;
        input [13:0] a;
        reg [12:0] x;
        reg [25:0] p;
        reg [15:0] m;
        begin
            x = a[12:0];
            p = {13'h0000, x} * {13'h0000, 13'h1FFF - x};
            m = p[24:9];
            sin_ap = a[13] ? -$signed({1'b0, m[14:0]}) : $signed({1'b0, m[14:0]});
        end
    endfunction

    reg signed [15:0] sin_q;
    reg signed [15:0] cos_q;
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            sin_q <= 16'sh0000;
            cos_q <= 16'sh0000;
        end
        else
        begin
            sin_q <= sin_ap(ang);
            cos_q <= sin_ap(ang + 14'h1000); // quarter turn ahead, see [R4]
        end
    end

    // =====================================================
    // modulator / single tone
    reg signed [35:0] mix_q;
    wire signed [33:0] ip = $signed(bb_i_i) * cos_q;
    wire signed [33:0] qp = $signed(bb_q_i) * sin_q;
    wire signed [15:0] tone = ctrl_q[`QUP_CTRL_SINE_BIT] ? sin_q : cos_q; // see [R6]
    wire signed [30:0] tone_sc = tone * $signed({1'b0, amplitude_scale_value}); // see [R9]
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
            mix_q <= 36'sh0;
        else if (ctrl_q[`QUP_CTRL_MODE_BIT])
            mix_q <= inv ? ({ip[33], ip[33], ip} + {qp[33], qp[33], qp})
                         : ({ip[33], ip[33], ip} - {qp[33], qp[33], qp}); // see [R3] [R4] [R5]
        else if (cfg2_q[`QUP_CFG2_ASF_BYP_BIT])
            mix_q <= {{2{tone[15]}}, tone, 18'h00000}; // see [R10]
        else
            mix_q <= {{5{tone_sc[30]}}, tone_sc} <<< 3;
    end
    wire signed [15:0] mix16 = mix_q[34:19];

    // =====================================================
    // output gain with saturation
    reg signed [15:0] gain_q;
    wire signed [24:0] gp = mix16 * $signed({1'b0, output_gain_factor});
    wire signed [17:0] gs = gp[24:7];
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
            gain_q <= 16'sh0000;
        else if (output_gain_factor == `QUP_OSF_UNITY | ~ctrl_q[`QUP_CTRL_MODE_BIT])
            gain_q <= mix16; // see [R16]
        else if (gs > 18'sd32767)
            gain_q <= 16'sh7FFF; // see [R21]
        else if (gs < -18'sd32768)
            gain_q <= 16'sh8000; // see [R21]
        else
            gain_q <= gs[15:0]; // see [R15]
    end

    // =====================================================
    // inverse sinc fir, symmetric 7 taps
    reg signed [15:0] tap_q [0:6];
    genvar g;
    generate
        for (g = 1; g < 7; g = g + 1)
        begin : g_dly
            always @(posedge ref_clk_i)
            begin
                if (srst_i)
                    tap_q[g] <= 16'sh0000;
                else
                    tap_q[g] <= tap_q[g-1];
            end
        end
    endgenerate
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
            tap_q[0] <= 16'sh0000;
        else
            tap_q[0] <= gain_q; // see [R14]
    end
    wire signed [32:0] fsum = (tap_q[0] + tap_q[6]) * `QUP_TAP0 + (tap_q[1] + tap_q[5]) * `QUP_TAP1
        + (tap_q[2] + tap_q[4]) * `QUP_TAP2 + tap_q[3] * `QUP_TAP3; // see [R13]
    wire signed [19:0] fsc = fsum[32:13];

    // dac output and auxiliary code
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            dac_data_o <= {DW{1'b0}};
            aux_dac_code_o <= `QUP_AUX_RST;
            cci_bypass_o <= 1'b1;
        end
        else
        begin
            if (~ctrl_q[`QUP_CTRL_ISINC_BIT])
                dac_data_o <= tap_q[3][15:16-DW]; // bypass, same latency, see [R13]
            else if (fsc > 20'sd32767)
                dac_data_o <= {1'b0, {(DW-1){1'b1}}};
            else if (fsc < -20'sd32768)
                dac_data_o <= {1'b1, {(DW-1){1'b0}}};
            else
                dac_data_o <= fsc[15:16-DW];
            aux_dac_code_o <= aux_q; // see [R18]
            cci_bypass_o <= (cci_q == 6'h01); // see [R19]
        end
    end
endmodule
`default_nettype wire

/* File: dv/qup_output_monitor.sv */
`default_nettype none
// ==========================================
// bus and control port checker
module qup_output_monitor (
    input wire logic ref_clk_i, // system clock
    input wire logic srst_i, // sync reset
    input wire logic [3:0] avs_address_i, // word index
    input wire logic avs_read_i, // read strobe
    input wire logic avs_write_i, // write strobe
    input wire logic [31:0] avs_writedata_i, // write data
    input wire logic [3:0] avs_byteenable_i, // byte lanes
    input wire logic [31:0] avs_readdata_o, // read data
    input wire logic avs_waitrequest_o, // stall
    input wire logic [13:0] dac_data_o, // dac sample
    input wire logic [7:0] aux_dac_code_o, // aux code
    input wire logic cci_bypass_o // cci bypass
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // aux word write accepted at this edge
    wire aux_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h4;
    AST_ACK_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("ack held over one cycle");
    AST_ACK_TIME: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
        else $error("ack not one cycle after request");
    AST_IDLE_STALL: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
        else $error("ack without request");
    AST_RST_OUT: assert property ($fell(srst_i) |-> aux_dac_code_o == 8'h7F && cci_bypass_o && dac_data_o == 14'h0)
        else $error("bad outputs after reset");
    AST_AUX_WR: assert property (aux_wr && avs_byteenable_i[0] |=> aux_dac_code_o == $past(avs_writedata_i[7:0]))
        else $error("aux code not written");
    AST_AUX_HOLD: assert property (!aux_wr |=> $stable(aux_dac_code_o))
        else $error("aux code changed alone");
    AST_CCI_WR: assert property (aux_wr && avs_byteenable_i[1] |=> cci_bypass_o == ($past(avs_writedata_i[13:8]) == 6'h01))
        else $error("cci bypass wrong");
    AST_CCI_HOLD: assert property (!aux_wr |=> $stable(cci_bypass_o))
        else $error("cci bypass changed alone");
    AST_MISS_RD: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[3:1] == 3'h3 |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    COV_AUX: cover property (aux_wr);
    COV_BYP_OFF: cover property ($fell(cci_bypass_o));
    COV_READ: cover property (avs_read_i && !avs_waitrequest_o);
endmodule
bind qup_output qup_output_monitor u_mon (.ref_clk_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .dac_data_o, .aux_dac_code_o,
    .cci_bypass_o);
`default_nettype wire

/* File: dv/qup_bb_src.sv */
`default_nettype none
// ==========================================
// interpolated baseband chain stand-in
module qup_bb_src (
    input wire logic ref_clk_i, // system clock
    input wire logic quiet_i, // hold samples at zero
    output logic [17:0] bb_i_o = 18'h0, // i sample
    output logic [17:0] bb_q_o = 18'h0 // q sample
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] sr_q = 32'h1;
    // fresh pair every clock, the stream never pauses
    always @(posedge ref_clk_i)
    begin
        sr_q <= {sr_q[30:0], sr_q[31] ^ sr_q[21] ^ sr_q[1] ^ sr_q[0]};
        bb_i_o <= quiet_i ? 18'h0 : sr_q[17:0];
        bb_q_o <= quiet_i ? 18'h0 : sr_q[31:14];
    end
endmodule
`default_nettype wire

/* File: dv/tb_qup_output.sv */
`default_nettype none
// ==========================================
// register, accumulator and output checks
module tb_qup_output;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic quiet = 1'b0;
    logic [31:0] seed = 32'h80CD7966;
    logic [31:0] exq[$];
    logic [31:0] pv[8];
    logic [31:0] rdat, q, w, a0, a1, nz;
    logic [17:0] bbi, bbq;
    logic [13:0] dac;
    logic [7:0] aux;
    logic wq, byp;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    int tcap, t0;
    qup_output dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wq), .bb_i_i(bbi), .bb_q_i(bbq), .dac_data_o(dac), .aux_dac_code_o(aux),
        .cci_bypass_o(byp));
    qup_bb_src u_src (.ref_clk_i(ref_clk_i), .quiet_i(quiet), .bb_i_o(bbi), .bb_q_o(bbq));
    // clock and cycle count
    initial forever #25 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) cyc <= cyc + 1;
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        // a read note never answered is a failure too
        if (exq.size() != 0)
            n_fail++;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one bus access; request held until waitrequest is seen low
    task automatic bus(input logic w_, input logic [3:0] a, input logic [31:0] d, input logic c,
        input logic [31:0] e, output logic [31:0] r);
        int k = 0;
        if (c && !w_)
            exq.push_back(e);
        rd <= !w_;
        wr <= w_;
        adr <= a;
        wdat <= d;
        @(posedge ref_clk_i);
        while (wq !== 1'b0 && k < 100)
        begin
            @(posedge ref_clk_i);
            k++;
        end
        r = rdat;
        tcap = cyc;
        rd <= 1'b0;
        wr <= 1'b0;
        if (k >= 100)
        begin
            n_fail++;
            close_out();
        end
        @(posedge ref_clk_i);
    endtask
    // oldest note compared as each read is answered
    always @(posedge ref_clk_i)
        if (rd && wq === 1'b0 && exq.size() > 0)
            check(rdat, exq.pop_front());
    initial
    begin
        repeat (8) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(posedge ref_clk_i);
        check({24'h0, aux}, 32'h7F);
        check({31'h0, byp}, 32'h1);
        bus(1'b0, 4'h4, 32'h0, 1'b1, 32'h17F, q);
        $display("test reset done");
        bus(1'b1, 4'h1, 32'hFFFFFFFF, 1'b0, 32'h0, q);
        bus(1'b0, 4'h1, 32'h0, 1'b1, 32'h7FFFFFFF, q);
        // factor 5 meets the minimum of every clock band and input mode
        w = {18'h0, 6'h05, 8'(rnd())};
        bus(1'b1, 4'h4, w, 1'b0, 32'h0, q);
        bus(1'b0, 4'h4, 32'h0, 1'b1, w, q);
        check({24'h0, aux}, {24'h0, w[7:0]});
        check({31'h0, byp}, 32'h0);
        bus(1'b1, 4'h7, w, 1'b0, 32'h0, q);
        bus(1'b0, 4'h7, 32'h0, 1'b1, 32'h0, q);
        $display("test registers done");
        for (int p = 0; p < 8; p++)
        begin
            pv[p] = rnd() & 32'h0FFFFFFF;
            bus(1'b1, 4'(8 + p), pv[p], 1'b0, 32'h0, q);
        end
        for (int p = 0; p < 8; p++)
            bus(1'b0, 4'(8 + p), 32'h0, 1'b1, pv[p], q);
        $display("test profiles done");
        // retune twice; accumulator step must follow each new word
        repeat (2)
        begin
            w = rnd() & 32'h7FFFFFFF;
            bus(1'b1, 4'h1, w, 1'b0, 32'h0, q);
            bus(1'b0, 4'h5, 32'h0, 1'b0, 32'h0, a0);
            t0 = tcap;
            bus(1'b0, 4'h5, 32'h0, 1'b0, 32'h0, a1);
            check(a1 - a0, w * 32'(tcap - t0));
        end
        $display("test accumulator done");
        quiet <= 1'b1;
        bus(1'b1, 4'h0, 32'h1, 1'b0, 32'h0, q);
        repeat (16) @(posedge ref_clk_i);
        check({18'h0, dac}, 32'h0);
        bus(1'b1, 4'h8, 32'h0, 1'b0, 32'h0, q);
        // unity gain keeps the output clear of clipping
        bus(1'b1, 4'h3, 32'h8000, 1'b0, 32'h0, q);
        bus(1'b1, 4'h0, 32'h0, 1'b0, 32'h0, q);
        repeat (16) @(posedge ref_clk_i);
        check({18'h0, dac}, 32'h0);
        bus(1'b1, 4'h2, 32'h01000000, 1'b0, 32'h0, q);
        nz = 32'h0;
        repeat (32)
        begin
            @(posedge ref_clk_i);
            nz = nz | {31'h0, dac !== 14'h0};
        end
        check(nz, 32'h1);
        $display("test datapath done");
        // mid-run reset: tuning word and accumulator back to zero, phase then set by offset alone
        srst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(posedge ref_clk_i);
        check({24'h0, aux}, 32'h7F);
        check({31'h0, byp}, 32'h1);
        bus(1'b1, 4'h2, 32'h01000000, 1'b0, 32'h0, q);
        bus(1'b1, 4'h0, 32'h2, 1'b0, 32'h0, q);
        repeat (16) @(posedge ref_clk_i);
        check({18'h0, dac}, 32'h0);
        bus(1'b1, 4'h8, 32'h04000000, 1'b0, 32'h0, q);
        repeat (16) @(posedge ref_clk_i);
        check({31'h0, dac[13] | (dac == 14'h0)}, 32'h0);
        bus(1'b1, 4'h8, 32'h0C000000, 1'b0, 32'h0, q);
        repeat (16) @(posedge ref_clk_i);
        check({31'h0, dac[13]}, 32'h1);
        $display("test phase offset done");
        close_out();
    end
endmodule
`default_nettype wire
